// ===== hw/debug_write_command_unit.sv
// Debug port write side: reset control, staged write value, commands and bus grant
// Summary of operation
// - Writing 1 to bit 7 at 11h resets the device; cleared when reset ends.
// - Host writes to master control wake the processor from halt or sleep.
// - Bytes 13h, 14h, 15h stage a 24-bit value used by write commands.
// - Narrower write commands use only the low byte or bytes of the staged value.
// - Each valid command register write starts its operation at once; one written while a request is pending is dropped.
// - Reads fill upper, high, low read bytes; AF gives page base, flags, accumulator.
// - Codes 00-07 read AF, BC, DE, HL, IX, IY, SP, PC; 80-87 write them.
// - Stack pointer commands pick long pointer in long mode, short pointer otherwise.
// - 08 sets long-address mode, 09 clears it, 0A swaps the alternate set.
// - 0B reads memory at PC then increments; 8B writes memory there then increments.
// - Bus control register governs bus requests in debug mode.
// - Bit 7 clear ignores requests; set grants them after the current operation.
// - Bit 6 set forces bus grant active; clearing it returns the bus unless an automatic grant from bit 7 holds it.
`timescale 1ns/1ns
module debug_write_command_unit #(
  parameter int IDLE_CYC = dbg_cmd_pkg::LINK_IDLE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire dbg_cmd_pkg::reg_wr_s reg_wr_i,
  input wire logic debug_clk_i,
  input wire logic bus_request_in_i,
  input wire logic long_address_mode_i,
  input wire logic reset_done_i,
  input wire logic core_done_i,
  input wire logic [23:0] core_rd_data_i,
  output dbg_cmd_pkg::core_req_s core_req_o,
  output logic device_reset_o,
  output logic wake_o,
  output logic [23:0] read_data_o,
  output logic read_update_o,
  output logic bus_grant_out_o
);

  dbg_cmd_pkg::unit_state_s st;
  dbg_cmd_pkg::unit_state_s next_st;
  logic [1:0] pins_sync;
  logic link_clk;
  logic bus_req;
  logic wr_master;
  logic wr_cmd;
  logic wr_bus;
  logic cmd_ok;
  logic cmd_write;
  dbg_cmd_pkg::target_e cmd_target;

  // ------------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------------
  sync_2ff #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i({debug_clk_i, bus_request_in_i}),
    .sync_o(pins_sync)
  );

  assign link_clk = pins_sync[1];
  assign bus_req = pins_sync[0];

  // Low bytes that a target actually uses; the rest read as zero
  function automatic logic [23:0] width_mask(input dbg_cmd_pkg::target_e t);
    logic [23:0] m;
    m = 24'hFF_FFFF;
    if (t == dbg_cmd_pkg::TGT_SPS) begin
      m = 24'h00_FFFF;
    end else if (t == dbg_cmd_pkg::TGT_MEM) begin
      m = 24'h00_00FF;
    end
    return m;
  endfunction

  // ------------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------------
  // Register strobes; address decode only, no readable registers here
  assign wr_master = reg_wr_i.en && (reg_wr_i.addr == dbg_cmd_pkg::ADDR_MASTER_CTL);
  assign wr_cmd = reg_wr_i.en && (reg_wr_i.addr == dbg_cmd_pkg::ADDR_COMMAND);
  assign wr_bus = reg_wr_i.en && (reg_wr_i.addr == dbg_cmd_pkg::ADDR_BUS_CTL);

  // Decode code to target; codes outside the table stay invalid
  always_comb begin
    cmd_ok = 1'b0;
    cmd_write = reg_wr_i.data[7];
    cmd_target = dbg_cmd_pkg::TGT_AF;
    if (reg_wr_i.data[6:0] <= dbg_cmd_pkg::CMD_RD_PC[6:0]) begin
      cmd_ok = 1'b1;
      cmd_target = dbg_cmd_pkg::target_e'({1'b0, reg_wr_i.data[2:0]});
      if (reg_wr_i.data[2:0] == 3'h6 && !long_address_mode_i) begin
        cmd_target = dbg_cmd_pkg::TGT_SPS;
      end
    end else if (reg_wr_i.data[6:0] == dbg_cmd_pkg::CMD_RD_MEM[6:0]) begin
      cmd_ok = 1'b1;
      cmd_target = dbg_cmd_pkg::TGT_MEM;
    end else if (!reg_wr_i.data[7]) begin
      // Mode and exchange commands exist only in the read half
      unique case (reg_wr_i.data)
        dbg_cmd_pkg::CMD_SET_LONG: begin
          cmd_ok = 1'b1;
          cmd_target = dbg_cmd_pkg::TGT_SET_LONG;
        end
        dbg_cmd_pkg::CMD_CLR_LONG: begin
          cmd_ok = 1'b1;
          cmd_target = dbg_cmd_pkg::TGT_CLR_LONG;
        end
        dbg_cmd_pkg::CMD_EXCHANGE: begin
          cmd_ok = 1'b1;
          cmd_target = dbg_cmd_pkg::TGT_EXCHANGE;
        end
        default: begin
          cmd_ok = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.wake = 1'b0;
    next_st.read_update = 1'b0;
    next_st.link_prev = link_clk;
    // Any link clock edge means a debug operation is in flight
    if (link_clk != st.link_prev) begin
      next_st.idle_cnt = '0;
    end else if (st.idle_cnt != 8'(IDLE_CYC)) begin
      next_st.idle_cnt = st.idle_cnt + 8'd1;
    end
    // Reset request ends with the reset; a new request in that cycle wins
    if (reset_done_i) begin
      next_st.reset_req = 1'b0;
    end
    if (wr_master) begin
      next_st.wake = 1'b1;
      if (reg_wr_i.data[dbg_cmd_pkg::BIT_DEVICE_RESET]) begin
        next_st.reset_req = 1'b1;
      end
    end
    // Staged bytes change only on their own writes
    if (reg_wr_i.en && reg_wr_i.addr == dbg_cmd_pkg::ADDR_WR_UPPER) begin
      next_st.staged[23:16] = reg_wr_i.data;
    end
    if (reg_wr_i.en && reg_wr_i.addr == dbg_cmd_pkg::ADDR_WR_HIGH) begin
      next_st.staged[15:8] = reg_wr_i.data;
    end
    if (reg_wr_i.en && reg_wr_i.addr == dbg_cmd_pkg::ADDR_WR_LOW) begin
      next_st.staged[7:0] = reg_wr_i.data;
    end
    // Finished request: reads land in the read bytes, low-justified
    if (st.req.valid && core_done_i) begin
      next_st.req.valid = 1'b0;
      if (!st.req.write && st.req.target != dbg_cmd_pkg::TGT_SET_LONG &&
          st.req.target != dbg_cmd_pkg::TGT_CLR_LONG &&
          st.req.target != dbg_cmd_pkg::TGT_EXCHANGE) begin
        next_st.read_data = core_rd_data_i & width_mask(st.req.target);
        next_st.read_update = 1'b1;
      end
    end
    // A command while one is pending is dropped: the core owns the old one
    if (wr_cmd && cmd_ok && !st.req.valid) begin
      next_st.req.valid = 1'b1;
      next_st.req.write = cmd_write;
      next_st.req.target = cmd_target;
      next_st.req.data = st.staged & width_mask(cmd_target);
    end
    // Reserved bits of bus control are dropped
    if (wr_bus) begin
      next_st.grant_en = reg_wr_i.data[dbg_cmd_pkg::BIT_GRANT_ENABLE];
      next_st.grant_force = reg_wr_i.data[dbg_cmd_pkg::BIT_GRANT_FORCE];
    end
    // Grant waits for the current operation and an idle link
    if (!next_st.grant_en || !bus_req) begin
      next_st.grant_auto = 1'b0;
    end else if (!st.req.valid && st.idle_cnt == 8'(IDLE_CYC)) begin
      next_st.grant_auto = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '{reset_req: 1'b0, wake: 1'b0, staged: dbg_cmd_pkg::STAGED_RESET,
              req: '{valid: 1'b0, write: 1'b0, target: dbg_cmd_pkg::TGT_AF,
                     data: 24'h00_0000},
              read_data: dbg_cmd_pkg::READ_RESET, read_update: 1'b0,
              grant_en: 1'b0, grant_force: 1'b0, grant_auto: 1'b0,
              idle_cnt: 8'h00, link_prev: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flip-flops; bus grant is the OR of the forced and automatic grant flops
  assign core_req_o = st.req;
  assign device_reset_o = st.reset_req;
  assign wake_o = st.wake;
  assign read_data_o = st.read_data;
  assign read_update_o = st.read_update;
  assign bus_grant_out_o = st.grant_force | st.grant_auto;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_reset_write;
    wr_master && reg_wr_i.data[dbg_cmd_pkg::BIT_DEVICE_RESET];
  endsequence

  sequence s_cmd_accept;
    wr_cmd && cmd_ok && !st.req.valid;
  endsequence

  a_reset_start: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_reset_write |=> device_reset_o) else $error("reset not started");

  a_reset_end: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    device_reset_o && reset_done_i && !wr_master |=> !device_reset_o)
    else $error("reset not cleared");

  a_wake_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_master |=> wake_o ##1 !wake_o || $past(wr_master))
    else $error("wake missing");

  a_cmd_issue: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_cmd_accept |=> core_req_o.valid && core_req_o.write == $past(reg_wr_i.data[7]))
    else $error("command not issued");

  a_short_data: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    core_req_o.valid && core_req_o.target == dbg_cmd_pkg::TGT_MEM |->
    core_req_o.data[23:8] == 16'h0000) else $error("memory data not masked");

  a_sp_select: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_cmd_accept ##0 (reg_wr_i.data[2:0] == 3'h6 && reg_wr_i.data[6:3] == 4'h0) |=>
    core_req_o.target == ($past(long_address_mode_i) ? dbg_cmd_pkg::TGT_SPL :
    dbg_cmd_pkg::TGT_SPS)) else $error("wrong stack pointer");

  a_staged_kept: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_cmd |=> $stable(st.staged)) else $error("staged value changed");

  a_read_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    read_update_o |-> $past(st.req.valid) && !$past(st.req.write) && $past(core_done_i))
    else $error("read data without read");

  a_grant_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !st.grant_en && !st.grant_force |-> !bus_grant_out_o)
    else $error("grant while disabled");

  a_grant_force: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_bus && reg_wr_i.data[dbg_cmd_pkg::BIT_GRANT_FORCE] |=> bus_grant_out_o)
    else $error("forced grant missing");

  a_reserved_cmd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_cmd && !cmd_ok && !st.req.valid |=> !core_req_o.valid)
    else $error("reserved code acted");

endmodule

// ===== hw/dbg_cmd_pkg.sv
// Package: register map, command codes, timing and carrier types of the debug write unit
package dbg_cmd_pkg;

  // ------------------------------------------------------------------
  // Register offsets in the write-only debug register space
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_MASTER_CTL = 8'h11;
  localparam logic [7:0] ADDR_WR_UPPER = 8'h13;
  localparam logic [7:0] ADDR_WR_HIGH = 8'h14;
  localparam logic [7:0] ADDR_WR_LOW = 8'h15;
  localparam logic [7:0] ADDR_COMMAND = 8'h16;
  localparam logic [7:0] ADDR_BUS_CTL = 8'h17;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int BIT_DEVICE_RESET = 7;
  localparam int BIT_GRANT_ENABLE = 7;
  localparam int BIT_GRANT_FORCE = 6;
  localparam logic [23:0] STAGED_RESET = 24'h00_0000;
  localparam logic [23:0] READ_RESET = 24'h00_0000;

  // ------------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_RD_AF = 8'h00;
  localparam logic [7:0] CMD_RD_PC = 8'h07;
  localparam logic [7:0] CMD_SET_LONG = 8'h08;
  localparam logic [7:0] CMD_CLR_LONG = 8'h09;
  localparam logic [7:0] CMD_EXCHANGE = 8'h0A;
  localparam logic [7:0] CMD_RD_MEM = 8'h0B;
  localparam logic [7:0] CMD_WR_AF = 8'h80;
  localparam logic [7:0] CMD_WR_PC = 8'h87;
  localparam logic [7:0] CMD_WR_MEM = 8'h8B;

  // ------------------------------------------------------------------
  // Timing: the link counts as idle after two link clock periods
  // ------------------------------------------------------------------
  localparam int CLK_SYS_MHZ = 100;
  localparam int LINK_IDLE_NS = 320;
  localparam int LINK_IDLE_CYC = (LINK_IDLE_NS * CLK_SYS_MHZ + 999) / 1000;

  // Target of a core request
  typedef enum logic [3:0] {
    TGT_AF = 4'b0000,
    TGT_BC = 4'b0001,
    TGT_DE = 4'b0010,
    TGT_HL = 4'b0011,
    TGT_IX = 4'b0100,
    TGT_IY = 4'b0101,
    TGT_SPL = 4'b0110,
    TGT_PC = 4'b0111,
    TGT_SPS = 4'b1000,
    TGT_SET_LONG = 4'b1001,
    TGT_CLR_LONG = 4'b1010,
    TGT_EXCHANGE = 4'b1011,
    TGT_MEM = 4'b1100
  } target_e;

  // One register write from the serial framing logic
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_s;

  // Request to the processor core
  typedef struct packed {
    logic valid;
    logic write;
    target_e target;
    logic [23:0] data;
  } core_req_s;

  // Whole state of the command unit
  typedef struct packed {
    logic reset_req;
    logic wake;
    logic [23:0] staged;
    core_req_s req;
    logic [23:0] read_data;
    logic read_update;
    logic grant_en;
    logic grant_force;
    logic grant_auto;
    logic [7:0] idle_cnt;
    logic link_prev;
  } unit_state_s;

endpackage

// ===== hw/sync_2ff.sv
// Two flip-flop synchroniser for level inputs from outside the clock domain
`timescale 1ns/1ns
module sync_2ff #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// ===== tb/dbg_host_model.sv
// Debug host model: link clock and deframed register writes
`timescale 1ns/1ns
module dbg_host_model (
  input wire logic clk_sys_i,
  output dbg_cmd_pkg::reg_wr_s reg_wr_o,
  output logic debug_clk_o
);
  // ----------------------------------------------------------------
  // Frames
  // ----------------------------------------------------------------
  logic framing;
  // Link clock toggles only inside a frame, phase unrelated to clk_sys_i;
  // a high phase is finished after the frame so the idle link rests low
  initial begin
    framing = 1'b0;
    reg_wr_o = '0;
    debug_clk_o = 1'b0;
    #37;
    forever #80 if (framing || debug_clk_o) debug_clk_o = ~debug_clk_o;
  end
  // One frame sends n bytes to consecutive addresses, back to back
  task automatic send(input logic [7:0] a, input logic [31:0] b, input int n);
    framing = 1'b1;
    repeat (16) @(posedge clk_sys_i);
    for (int i = 0; i < n; i++) begin
      reg_wr_o <= '{1'b1, a + 8'(i), b[8*(n-1-i) +: 8]};
      @(posedge clk_sys_i);
    end
    reg_wr_o.en <= 1'b0;
    framing = 1'b0;
  endtask
endmodule

// ===== tb/debug_write_command_unit_tb_top.sv
// Testbench: commands, staged data, reset control and bus grant
`timescale 1ns/1ns
module debug_write_command_unit_tb_top;
  logic clk, rst, breq, lmode, rdone, cdone, rst_o, wake, rupd, grant, lclk, pv;
  logic [23:0] crd, rdat, staged;
  dbg_cmd_pkg::reg_wr_s wr;
  dbg_cmd_pkg::core_req_s req;
  logic [28:0] req_q[$];
  logic [23:0] rd_q[$];
  logic [15:0] seed = 16'h001B;
  logic [7:0] rsv[4] = '{8'h88, 8'h89, 8'h8A, 8'h0C};
  int error_cnt = 0;
  int checks = 0;
  int wakes = 0;

  dbg_host_model host (.clk_sys_i(clk), .reg_wr_o(wr), .debug_clk_o(lclk));
  debug_write_command_unit #(.IDLE_CYC(4)) DUT (.clk_sys_i(clk), .rst_i(rst),
    .reg_wr_i(wr), .debug_clk_i(lclk), .bus_request_in_i(breq),
    .long_address_mode_i(lmode), .reset_done_i(rdone), .core_done_i(cdone),
    .core_rd_data_i(crd), .core_req_o(req), .device_reset_o(rst_o), .wake_o(wake),
    .read_data_o(rdat), .read_update_o(rupd), .bus_grant_out_o(grant));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [28:0] got, input logic [28:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Waits, bounded, until the core has finished the open request
  task automatic settle;
    @(posedge clk);
    for (int i = 0; i < 40 && req.valid !== 1'b0; i++) @(posedge clk);
  endtask
  // Notes the expected request, then sends the command byte alone
  task automatic cmd(input logic [7:0] c);
    logic [3:0] t;
    logic [23:0] d;
    t = (c[3:0] == 4'h6 && !lmode) ? 4'h8 : c[3:0] + {3'b000, c[3:0] > 4'h7};
    d = !c[7] ? 24'h00_0000 : t == 4'h8 ? {8'h00, staged[15:0]} :
        t == 4'hC ? {16'h0000, staged[7:0]} : staged;
    if (c[6:0] <= 7'h0B && !(c[7] && t inside {4'h9, 4'hA, 4'hB})) begin
      req_q.push_back({c[7], t, d});
    end
    host.send(dbg_cmd_pkg::ADDR_COMMAND, {24'h00_0000, c}, 1);
    settle();
  endtask
  task automatic bus_wr(input logic [7:0] v);
    host.send(dbg_cmd_pkg::ADDR_BUS_CTL, {24'h00_0000, v}, 1);
    repeat (2) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Core partner and output watcher
  // ----------------------------------------------------------------
  // Core answers after 0 to 7 cycles; the read result is masked to the target width
  initial forever begin
    @(posedge clk);
    if (req.valid === 1'b1) begin
      seed = lfsr(seed);
      repeat (seed[2:0]) @(posedge clk);
      crd <= {seed[7:0], seed};
      cdone <= 1'b1;
      if (!req.write && !(req.target inside {4'h9, 4'hA, 4'hB})) begin
        rd_q.push_back(req.target == 4'h8 ? {8'h00, seed} :
                       req.target == 4'hC ? {16'h0000, seed[7:0]} : {seed[7:0], seed});
      end
      @(posedge clk);
      cdone <= 1'b0;
    end
  end
  // Each new request and each read result takes the oldest note
  always @(posedge clk) begin
    pv <= req.valid;
    if (wake === 1'b1) wakes++;
    if (req.valid === 1'b1 && pv !== 1'b1) begin
      chk({req.write, req.target, req.write ? req.data : 24'h00_0000},
          req_q.size() > 0 ? req_q.pop_front() : 29'hx);
    end
    if (rupd === 1'b1) begin
      chk({5'h00, rdat}, {5'h00, rd_q.size() > 0 ? rd_q.pop_front() : 24'hx});
    end
  end
  initial begin
    #200_000;
    error_cnt++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    breq = 1'b0;
    lmode = 1'b1;
    rdone = 1'b0;
    cdone = 1'b0;
    crd = 24'h00_0000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({rst_o, grant, req.valid, wake, rupd, rdat}, 29'h0);
    $display("test reset values done");
    seed = lfsr(seed);
    staged = {seed[7:0], seed};
    req_q.push_back({1'b1, 4'h7, staged});
    host.send(dbg_cmd_pkg::ADDR_WR_UPPER, {staged, 8'h87}, 4);
    settle();
    for (int c = 8'h80; c <= 8'h86; c++) cmd(8'(c));
    lmode <= 1'b0;
    // Let the new mode settle before the expectation is worked out from it
    @(posedge clk);
    cmd(8'h86);
    cmd(8'h8B);
    cmd(8'h81);
    for (int c = 0; c <= 8'h0B; c++) cmd(8'(c));
    cmd(8'h00);
    foreach (rsv[i]) cmd(rsv[i]);
    $display("test commands done");
    wakes = 0;
    host.send(dbg_cmd_pkg::ADDR_MASTER_CTL, 32'h0000_007F, 1);
    repeat (2) @(posedge clk);
    chk(29'({rst_o, 5'(wakes)}), 29'h01);
    host.send(dbg_cmd_pkg::ADDR_MASTER_CTL, 32'h0000_0080, 1);
    repeat (2) @(posedge clk);
    chk(29'({rst_o, 5'(wakes)}), 29'h22);
    rdone <= 1'b1;
    @(posedge clk);
    rdone <= 1'b0;
    repeat (2) @(posedge clk);
    chk(29'(rst_o), 29'h0);
    $display("test master control done");
    bus_wr(8'h40);
    chk(29'(grant), 29'h1);
    bus_wr(8'h00);
    chk(29'(grant), 29'h0);
    breq <= 1'b1;
    repeat (60) @(posedge clk);
    chk(29'(grant), 29'h0);
    bus_wr(8'h80);
    for (int i = 0; i < 60 && grant !== 1'b1; i++) @(posedge clk);
    chk(29'(grant), 29'h1);
    breq <= 1'b0;
    repeat (8) @(posedge clk);
    chk(29'(grant), 29'h0);
    $display("test bus grant done");
    final_report();
  end
endmodule
